//--- src/srw_pkg.sv
// Purpose: constants for the system reset and ram wait block
// Assumes: 50 MHz system clock
// Notes: register offset is the byte address on the plain register port
package srw_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned STRETCH_US = 400;
    localparam int unsigned STRETCH_CYCLES = (CLK_HZ / 1_000_000) * STRETCH_US;
    localparam int unsigned PIN_LOW_MIN_CYCLES = 12;
    localparam int unsigned REG_SETTLE_US = 200;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] RAM_WAIT_STATE_CONTROL_ADDR = 32'h41FF_F058;
    localparam logic [31:0] PLL_SELECT_REGISTER_ADDR = 32'h400F_400C;
    localparam logic [31:0] RESET_CAUSE_ADDR = 32'h41FF_F05C;
    localparam logic [31:0] SECURITY_ADDR = 32'h41FF_F060;
    localparam int unsigned RAM_EXTRA_WAIT_POS = 0;
    localparam logic RAM_EXTRA_WAIT_RESET = 1'b1;
    localparam logic PLL_ENABLE_RESET = 1'b0;

    // ------------------------------------------------------------
    // boot vectors and slow ram region
    // ------------------------------------------------------------
    localparam logic [31:0] STACK_VECTOR_ADDR = 32'h0000_0000;
    localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
    localparam logic [31:0] SLOW_RAM_LO = 32'h2000_4000;
    localparam logic [31:0] SLOW_RAM_HI = 32'h2000_FFFF;

    typedef enum logic [2:0] {
        SRW_RESET, SRW_STRETCH, SRW_FETCH_SP, SRW_FETCH_PC, SRW_RUN
    } srw_state_type;
endpackage

//--- src/srw_top.sv
// Purpose: reset collection, stretch, boot vector fetch and ram wait bit
// Assumes: pin input already synchronous; one clock
// Notes: cold reset is the first pin release after power-up
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RL1 - pin, watchdog or core request resets system
// RL2 - no core reset request in slow mode
// RL3 - pin held low 200 us at power-up; not checked here, the stretch starts at the first pin release
// RL4 - internal reset stretched 400 us after release
// RL5 - warm reset pin low at least 12 clocks; the block resets on a pin low of any length
// RL6 - warm reset restores most control registers
// RL7 - debug, cause flag, security: cold only
// RL8 - pll off after reset until enabled
// RL9 - stack pointer word 0, handler word 4
// RL10 - core starts at fetched reset handler
// RL11 - upper ram one wait until cleared
// RL12 - bit 0 selects wait, resets one
// RL13 - ram contents undefined across reset
// RL14 - synchronise pin release, derive stretch length
module srw_top #(
    parameter int unsigned STRETCH = srw_pkg::STRETCH_CYCLES
) (
    // clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst,
    // reset sources
    input wire logic external_reset_pin_low,
    input wire logic watchdog_reset_source,
    input wire logic core_software_reset_request,
    input wire logic slow_clock_mode,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // core boot interface
    output logic sys_reset,
    output logic cold_reset,
    output logic core_hold,
    output logic vec_rd,
    output logic [31:0] vec_addr,
    input wire logic [31:0] vec_data,
    output logic [31:0] core_sp,
    output logic [31:0] core_pc,
    output logic core_start,
    // control outputs
    output logic pll_enable,
    output logic debug_units_reset,
    output logic ram_contents_valid,
    // ram access wait decision
    input wire logic [31:0] ram_addr,
    output logic ram_wait
);
    import srw_pkg::*;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // stretch counter is 24 bits; a longer stretch would wrap
    if (STRETCH < 1 || STRETCH > 32'h00FF_FFFF) begin : g_bad_stretch
        $error("srw_top: STRETCH out of range");
    end

    // ------------------------------------------------------------
    // reset sources and pin synchroniser
    // ------------------------------------------------------------
    logic pin_s1_q, pin_s2_q;
    logic req_q;
    logic src_reset;

    // pin treated as async to internal logic despite synchronous input
    // reset value is the asserted level: no false release after rst
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= external_reset_pin_low; // RL14
            pin_s2_q <= pin_s1_q; // RL14
        end
    end

    // core request in slow mode is ignored; software must not do it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= core_software_reset_request & ~slow_clock_mode; // RL2
        end
    end

    // watchdog is a level from this clock domain; no synchroniser
    assign src_reset = ~pin_s2_q | watchdog_reset_source | req_q; // RL1

    // ------------------------------------------------------------
    // sequencer: stretch then vector fetch
    // ------------------------------------------------------------
    srw_state_type state_q, state_d;
    logic [23:0] cnt_q;
    logic cold_q;
    logic [31:0] sp_q, pc_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SRW_RESET: begin
                if (!src_reset) begin
                    state_d = SRW_STRETCH;
                end
            end
            SRW_STRETCH: begin
                if (cnt_q == 24'(STRETCH - 1)) begin
                    state_d = SRW_FETCH_SP; // RL4
                end
            end
            SRW_FETCH_SP: state_d = SRW_FETCH_PC;
            SRW_FETCH_PC: state_d = SRW_RUN;
            SRW_RUN: state_d = SRW_RUN;
            default: state_d = SRW_RESET;
        endcase
        if (src_reset) begin
            state_d = SRW_RESET; // RL1
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= SRW_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // stretch counter restarts on every new reset
    always_ff @(posedge clk_sys) begin
        if (rst || state_q != SRW_STRETCH) begin
            cnt_q <= 24'h00_0000;
        end else begin
            cnt_q <= cnt_q + 24'h00_0001; // RL4 RL14
        end
    end

    // cold flag only cleared once the first reset completes
    // a reset cutting the first boot short still counts as cold
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cold_q <= 1'b1;
        end else if (state_q == SRW_RUN) begin
            cold_q <= 1'b0; // RL7
        end
    end

    // vector words captured one cycle after each read
    logic fetch_d1_q;
    logic fetch_pc_d1_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fetch_d1_q <= 1'b0;
            fetch_pc_d1_q <= 1'b0;
        end else begin
            fetch_d1_q <= (state_q == SRW_FETCH_SP);
            fetch_pc_d1_q <= (state_q == SRW_FETCH_PC);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sp_q <= 32'h0000_0000;
            pc_q <= 32'h0000_0000;
        end else begin
            if (fetch_d1_q) begin
                sp_q <= vec_data; // RL9
            end
            if (fetch_pc_d1_q) begin
                pc_q <= vec_data; // RL9 RL10
            end
        end
    end

    // ------------------------------------------------------------
    // register address decode, shared by write and read paths
    // ------------------------------------------------------------
    function automatic logic [3:0] reg_sel(input logic [31:0] addr);
        logic [3:0] sel;
        sel[0] = (addr == RAM_WAIT_STATE_CONTROL_ADDR);
        sel[1] = (addr == PLL_SELECT_REGISTER_ADDR);
        sel[2] = (addr == RESET_CAUSE_ADDR);
        sel[3] = (addr == SECURITY_ADDR);
        return sel;
    endfunction

    logic [3:0] wr_sel;
    // strobe gates the decode so an idle address never writes
    assign wr_sel = reg_wr ? reg_sel(reg_addr) : 4'h0;

    // no start pulse if a reset cuts the fetch short
    logic start_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= fetch_pc_d1_q & (state_q == SRW_RUN); // RL10
        end
    end

    // ------------------------------------------------------------
    // registers: warm-reset class and cold-only class
    // ------------------------------------------------------------
    logic warm_rst;
    logic ram_wait_q, pll_en_q, cause_q, secure_q;
    logic running_q;
    // core is held through the stretch, so no write may land there
    assign warm_rst = rst | sys_reset;

    always_ff @(posedge clk_sys) begin
        if (warm_rst) begin
            ram_wait_q <= RAM_EXTRA_WAIT_RESET; // RL6 RL11 RL12
            pll_en_q <= PLL_ENABLE_RESET; // RL6 RL8
        end else begin
            if (wr_sel[0]) begin
                ram_wait_q <= reg_wdata[RAM_EXTRA_WAIT_POS]; // RL12
            end
            if (wr_sel[1]) begin
                pll_en_q <= reg_wdata[0]; // RL8
            end
        end
    end

    // cause flag: set by any warm reset, cleared by writing 1
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cause_q <= 1'b0;
            secure_q <= 1'b0;
        end else begin
            if (state_q == SRW_RESET && !cold_q) begin
                cause_q <= 1'b1; // RL7
            end else if (wr_sel[2] && reg_wdata[0]) begin
                // set wins over a clear in the same cycle
                cause_q <= 1'b0;
            end
            // security bit is write-once until cold reset
            if (wr_sel[3] && reg_wdata[0]) begin
                secure_q <= 1'b1; // RL7
            end
        end
    end

    // ram marked invalid across every reset
    always_ff @(posedge clk_sys) begin
        if (warm_rst) begin
            running_q <= 1'b0; // RL13
        end else if (state_q == SRW_RUN) begin
            running_q <= 1'b1;
        end
    end

    // read word stands one cycle only, then returns to zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_sel(reg_addr))
                4'h1:
                    reg_rdata <= {31'h0000_0000, ram_wait_q}; // RL12
                4'h2:
                    reg_rdata <= {31'h0000_0000, pll_en_q};
                4'h4:
                    reg_rdata <= {31'h0000_0000, cause_q};
                4'h8:
                    reg_rdata <= {31'h0000_0000, secure_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the chip sees reset through the whole stretch
    assign sys_reset = (state_q == SRW_RESET) || (state_q == SRW_STRETCH);
    assign cold_reset = cold_q & sys_reset;
    assign debug_units_reset = cold_q & sys_reset; // RL7
    // hold drops in the cycle of the start pulse
    assign core_hold = (state_q != SRW_RUN) | fetch_pc_d1_q;
    assign vec_rd = (state_q == SRW_FETCH_SP) || (state_q == SRW_FETCH_PC);
    assign vec_addr = (state_q == SRW_FETCH_PC) ? RESET_VECTOR_ADDR
                                                : STACK_VECTOR_ADDR; // RL9
    assign core_sp = sp_q;
    assign core_pc = pc_q;
    assign core_start = start_q;
    assign pll_enable = pll_en_q;
    assign ram_contents_valid = running_q;
    // range test is combinational: the memory needs it in the access cycle
    assign ram_wait = ram_wait_q && (ram_addr >= SLOW_RAM_LO)
                      && (ram_addr <= SLOW_RAM_HI); // RL11
endmodule // srw_top
`default_nettype wire

//--- tb/srw_properties.sv
// Purpose: port checks for the reset and ram wait block
// Assumes: bound to srw_top, one clock, stretch from the bound parameter
// Notes: stretch bounds allow a few cycles of pin synchronising
`timescale 1ns/10ps
`default_nettype none
module srw_checker
import srw_pkg::*;
#(parameter int unsigned STRETCH = 8) (
    // clock and resets
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic external_reset_pin_low,
    input wire logic watchdog_reset_source,
    // watched outputs
    input wire logic sys_reset,
    input wire logic cold_reset,
    input wire logic debug_units_reset,
    input wire logic core_hold,
    input wire logic ram_contents_valid,
    input wire logic vec_rd,
    input wire logic [31:0] vec_addr,
    input wire logic core_start,
    input wire logic pll_enable,
    input wire logic [31:0] ram_addr,
    input wire logic ram_wait
);
    logic [15:0] held_q;
    logic slow_a;
    assign slow_a = ram_addr >= SLOW_RAM_LO && ram_addr <= SLOW_RAM_HI;
    // cycles of reset after the pin and watchdog sources have gone away
    always_ff @(posedge clk_sys) begin
        if (rst || !sys_reset || !external_reset_pin_low ||
            watchdog_reset_source)
            held_q <= 16'h0;
        else
            held_q <= held_q + 16'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_pin_resets: assert property (!external_reset_pin_low |-> ##[1:4]
        sys_reset) else $error("pin low did not reset");
    a_wd_resets: assert property (watchdog_reset_source |=> sys_reset)
        else $error("watchdog did not reset");
    a_stretch_len: assert property ($fell(sys_reset) |->
        held_q >= STRETCH && held_q <= STRETCH + 5)
        else $error("reset stretch length wrong");
    a_pll_off: assert property (sys_reset ##1 sys_reset |-> !pll_enable)
        else $error("pll on during reset");
    a_vec_order: assert property ($fell(sys_reset) |->
        vec_rd && vec_addr == STACK_VECTOR_ADDR ##1
        vec_rd && vec_addr == RESET_VECTOR_ADDR ##1 !vec_rd)
        else $error("vector fetch order wrong");
    a_core_start: assert property ($fell(vec_rd) |=> core_start
        ##1 !core_start) else $error("core start pulse wrong");
    a_wait_range: assert property (ram_wait |-> slow_a)
        else $error("wait outside slow ram");
    a_wait_reset: assert property (sys_reset ##1 sys_reset && slow_a
        |-> ram_wait) else $error("wait bit not one in reset");
    a_debug_cold: assert property (debug_units_reset == cold_reset &&
        (!cold_reset || sys_reset)) else $error("debug reset not cold");
    a_hold_reset: assert property (sys_reset |-> core_hold)
        else $error("core not held in reset");
    a_start_free: assert property (core_start |->
        !core_hold && ram_contents_valid) else $error("start while held");
    a_ram_invalid: assert property (sys_reset ##1 sys_reset |->
        !ram_contents_valid) else $error("ram valid during reset");
    cover property ($fell(sys_reset));
    cover property (core_start && !cold_reset);
    cover property (ram_wait);
endmodule // srw_checker
bind srw_top srw_checker #(.STRETCH(STRETCH)) i_chk (.clk_sys(clk_sys),
    .rst(rst), .external_reset_pin_low(external_reset_pin_low),
    .watchdog_reset_source(watchdog_reset_source), .sys_reset(sys_reset),
    .cold_reset(cold_reset), .debug_units_reset(debug_units_reset),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .core_start(core_start),
    .core_hold(core_hold), .ram_contents_valid(ram_contents_valid),
    .pll_enable(pll_enable), .ram_addr(ram_addr), .ram_wait(ram_wait));
`default_nettype wire

//--- tb/srw_vec_model.sv
// Purpose: boot vector table answering the block's fetches
// Assumes: word is wanted in the cycle after the fetch strobe
// Notes: data churns outside answers so stale words never match
`timescale 1ns/10ps
`default_nettype none
module srw_vec_model
import srw_pkg::*;
#(
    parameter logic [31:0] SP_WORD = 32'h2000_8000,
    parameter logic [31:0] PC_WORD = 32'h0000_0101
) (
    input wire logic clk_sys,
    input wire logic vec_rd,
    input wire logic [31:0] vec_addr,
    output logic [31:0] vec_data
);
    always_ff @(posedge clk_sys) begin
        if (vec_rd && vec_addr == STACK_VECTOR_ADDR)
            vec_data <= SP_WORD;
        else if (vec_rd && vec_addr == RESET_VECTOR_ADDR)
            vec_data <= PC_WORD;
        else
            vec_data <= ~vec_data;
    end
endmodule // srw_vec_model
`default_nettype wire

//--- tb/tb_system_reset_and_ram_wait.sv
// Purpose: self-checking bench for the reset and ram wait block
// Assumes: short stretch parameter, vector model on the boot port
// Notes: read results are queued at issue and compared by a monitor
`timescale 1ns/10ps
`default_nettype none
module tb_system_reset_and_ram_wait;
    import srw_pkg::*;
    localparam logic [31:0] SPV = 32'h2000_8000;
    localparam logic [31:0] PCV = 32'h0000_0101;
    logic clk_sys = 1'b0, rst = 1'b1, rst_pin_low = 1'b0, wd = 1'b0;
    logic req = 1'b0, slow = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic rd_seen = 1'b0, sys_reset, core_start, vec_rd, ram_wait;
    logic core_hold, ram_valid;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, ram_addr = SLOW_RAM_LO;
    logic [31:0] reg_rdata, vec_addr, vec_data, core_sp, core_pc;
    logic [31:0] exp_q [$];
    int fail_count = 0, total_checks = 0, seed = 32'hd4de;
    srw_top #(.STRETCH(8)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .external_reset_pin_low(rst_pin_low), .watchdog_reset_source(wd),
        .core_software_reset_request(req), .slow_clock_mode(slow),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_reset(sys_reset),
        .cold_reset(), .core_hold(core_hold), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_data(vec_data), .core_sp(core_sp),
        .core_pc(core_pc), .core_start(core_start), .pll_enable(),
        .debug_units_reset(), .ram_contents_valid(ram_valid),
        .ram_addr(ram_addr), .ram_wait(ram_wait));
    srw_vec_model #(.SP_WORD(SPV), .PC_WORD(PCV)) i_vec (.clk_sys(clk_sys),
        .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data));
    initial forever #10 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // read word stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_seen)
            check(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end
    task automatic ram_chk(input logic b);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            ram_addr <= i[1] ? SLOW_RAM_HI + i[0] : SLOW_RAM_LO - !i[0];
            @(negedge clk_sys);
            check({31'h0, ram_wait}, {31'h0, b && (i[0] ^ i[1])});
        end
    endtask
    task automatic boot();
        int n;
        for (n = 0; n < 200 && core_start !== 1'b1; n++)
            @(negedge clk_sys);
        check(core_sp, SPV);
        check(core_pc, PCV);
        check({31'h0, core_hold}, 32'h0);
        check({31'h0, ram_valid}, 32'h1);
        check({31'h0, n < 200}, 32'h1);
        rd(RAM_WAIT_STATE_CONTROL_ADDR, 32'h1);
        rd(PLL_SELECT_REGISTER_ADDR, 32'h0);
        ram_chk(1'b1);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_pin_low <= 1'b1;
        boot();
        rd(RESET_CAUSE_ADDR, 32'h0);
        rd(32'h41FF_F000, 32'h0);
        wr(RAM_WAIT_STATE_CONTROL_ADDR, $random(seed) & 32'hFFFF_FFFE);
        rd(RAM_WAIT_STATE_CONTROL_ADDR, 32'h0);
        ram_chk(1'b0);
        wr(PLL_SELECT_REGISTER_ADDR, 32'h1);
        rd(PLL_SELECT_REGISTER_ADDR, 32'h1);
        wr(SECURITY_ADDR, 32'h1);
        // shortest legal warm pulse on the pin
        @(posedge clk_sys);
        rst_pin_low <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_pin_low <= 1'b1;
        boot();
        rd(SECURITY_ADDR, 32'h1);
        rd(RESET_CAUSE_ADDR, 32'h1);
        @(posedge clk_sys);
        slow <= 1'b1;
        req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        req <= 1'b0;
        slow <= 1'b0;
        @(negedge clk_sys);
        check({31'h0, sys_reset}, 32'h0);
        @(posedge clk_sys);
        req <= 1'b1;
        @(posedge clk_sys);
        req <= 1'b0;
        boot();
        @(posedge clk_sys);
        wd <= 1'b1;
        @(posedge clk_sys);
        wd <= 1'b0;
        boot();
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule // tb_system_reset_and_ram_wait
`default_nettype wire
